// *** shared/wwd_pkg.sv ***
// constants, codes and carrier types of the windowed watchdog
// assumes a single 10 MHz core clock; all slower rates are enables
package wwd_pkg;

  // clock and oscillator rates
  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 31_000;
  // core cycles per oscillator tick, rounded down
  localparam int OSC_TICK_DIV = CLK_HZ / OSC_HZ;

  // prescaler ratios and the nominal base periods they give
  localparam int PRESC_SMALL   = 32;
  localparam int PRESC_LARGE   = 128;
  localparam int BASE_SMALL_US = 1000;
  localparam int BASE_LARGE_US = 4000;

  // counter spans 128 << 15 oscillator ticks
  localparam int CNT_W  = 22;
  localparam int APB_AW = 8;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFF_RST_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_ISTAT    = 8'h04;
  localparam logic [APB_AW-1:0] OFF_IMASK    = 8'h08;
  localparam logic [APB_AW-1:0] OFF_CFG      = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_COUNT    = 8'h10;

  // reset_control_reg field positions
  localparam int RC_SWEN  = 5;
  localparam int RC_TO    = 4;
  localparam int RC_SLEEP = 3;
  localparam int RC_IDLE  = 2;

  // hw_enable_mode codes
  localparam logic [1:0] HWEN_OFF    = 2'h0;
  localparam logic [1:0] HWEN_ACTIVE = 2'h1;
  localparam logic [1:0] HWEN_SW     = 2'h2;
  localparam logic [1:0] HWEN_ON     = 2'h3;

  // interrupt status bit positions
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_EARLY   = 1;
  localparam int IRQ_WAKE    = 2;
  localparam int IRQ_N       = 3;

  // reset values
  localparam logic [IRQ_N-1:0] IMASK_RST = 3'h0;
  localparam logic [7:0]       CFG_RST   = 8'h00;

  // power state of the core
  typedef enum logic [2:0] {
    PM_RUN   = 3'b001,
    PM_SLEEP = 3'b010,
    PM_IDLE  = 3'b100
  } wwd_pmode_t;

  // watchdog configuration word
  typedef struct packed {
    logic       windowDisable;
    logic [1:0] hwEnableMode;
    logic       prescaleSelect;
    logic [3:0] postscaleSelect;
  } wwd_cfg_t;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } wwd_apb_req_t;

endpackage

// *** rtl/wwd_low_power_rc_osc_div.sv ***
// oscillator tick generator: one-cycle enable at the low-power rc rate
// assumes ref_clk is the only clock; enable gates the oscillator
module wwd_osc_div
  import wwd_pkg::*;
#(
  parameter int DIV = OSC_TICK_DIV
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      tick
);

  if (DIV < 2 || DIV > 65535) begin : g_chk
    $error("wwd_osc_div: DIV out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } wwd_div_t;

  wwd_div_t s;
  wwd_div_t next_s;

  // oscillator stopped while disabled, so the phase restarts on enable
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!enable) begin
      next_s.cnt = 16'h0000;
    end else if (s.cnt == 16'(DIV - 1)) begin
      next_s.cnt = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule // wwd_osc_div

// *** rtl/wwd_irq.sv ***
// sticky interrupt status, read-to-clear, with mask and one level output
// assumes clear requests only name bits that software has already seen
module wwd_irq
  import wwd_pkg::*;
#(
  parameter int N = IRQ_N
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] evt,
  input  wire logic         rdClr,
  input  wire logic [N-1:0] clrMask,
  input  wire logic         maskWe,
  input  wire logic [N-1:0] maskWdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);

  if (N < 1 || N > 32) begin : g_chk
    $error("wwd_irq: N out of range");
  end

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } wwd_irq_st_t;

  wwd_irq_st_t s;
  wwd_irq_st_t next_s;

  // clearing only the bits read keeps an event of the same edge; set wins
  always_comb begin
    next_s = s;
    if (rdClr) begin
      next_s.status = s.status & ~clrMask;
    end
    next_s.status = next_s.status | evt;
    if (maskWe) begin
      next_s.mask = maskWdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{status: '0, mask: N'(IMASK_RST)};
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign mask   = s.mask;
  assign irq    = |(s.status & s.mask);

endmodule // wwd_irq

// *** rtl/wwd_top.sv ***
// windowed watchdog timer with apb registers and core event inputs
// assumes core ops are one-cycle pulses synchronous to ref_clk, that
// wdtResetReq resets the rest of the device and that rst_n is power-on
// only, so the time-out flag outlives the reset it requests
//
// Local design decisions: the register offsets and the APB slave port.
module wwd_top
  import wwd_pkg::*;
#(
  parameter int OSC_DIV = OSC_TICK_DIV
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire wwd_apb_req_t apbReq,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire wwd_cfg_t     wdtConfigWord,
  input  wire logic         watchdogClearOp,
  input  wire logic         powerSaveOp,
  input  wire logic         powerSaveIdle,
  input  wire logic         wakeEvent,
  input  wire logic         oscSwitchDone,
  output logic              wdtResetReq,
  output logic              wakeReq,
  output logic              lowPowerRcOscOn,
  output logic              irq
);

  if (OSC_DIV < 2) begin : g_chk
    $error("wwd_top: OSC_DIV too small");
  end

  typedef struct packed {
    wwd_pmode_t       mode;
    logic [CNT_W-1:0] count;
    wwd_cfg_t         cfg;
    logic             cfgLoaded;
    logic             swEnable;
    logic             toFlag;
    logic             sleepSt;
    logic             idleSt;
    logic             resetReq;
    logic             wakeReq;
    logic [31:0]      prdata;
  } wwd_state_t;

  // full period in oscillator ticks: prescale << postscale
  function automatic logic [CNT_W:0] periodOf(wwd_cfg_t c);
    logic [CNT_W:0] base;
    base = c.prescaleSelect ? (CNT_W+1)'(PRESC_LARGE)
                            : (CNT_W+1)'(PRESC_SMALL);
    return base << c.postscaleSelect;
  endfunction

  // enable decode from hw mode, sw bit and power state
  function automatic logic wdtOn(logic [1:0] hw, logic sw, wwd_pmode_t m);
    case (hw)
      HWEN_ON:     return 1'b1;
      HWEN_SW:     return sw;
      HWEN_ACTIVE: return m != PM_SLEEP;
      default:     return 1'b0;
    endcase
  endfunction

  function automatic logic addrHit(logic [APB_AW-1:0] a);
    return a == OFF_RST_CTRL || a == OFF_ISTAT || a == OFF_IMASK
        || a == OFF_CFG || a == OFF_COUNT;
  endfunction

  wwd_state_t s;
  wwd_state_t next_s;

  logic             on;
  logic             tick;
  logic [CNT_W:0]   period;
  logic [CNT_W:0]   winStart;
  logic [CNT_W-1:0] lastTick;
  logic             timeout;
  logic             early;
  logic             setup;
  logic             acc;
  logic             wrRstCtrl;
  logic             swFlagClr;
  logic [IRQ_N-1:0] evt;
  logic [IRQ_N-1:0] irqStatus;
  logic [IRQ_N-1:0] irqMask;
  logic [31:0]      rdMux;

  // timing figures derived from the sampled configuration
  assign on       = s.cfgLoaded && wdtOn(s.cfg.hwEnableMode, s.swEnable, s.mode);
  assign period   = periodOf(s.cfg);
  assign winStart = period - (period >> 2);
  assign lastTick = CNT_W'(period - 1'b1);
  assign timeout  = on && tick && s.count == lastTick;
  // early only while enabled, so a disabled watchdog ignores it
  assign early    = on && !s.cfg.windowDisable
                    && {1'b0, s.count} < winStart;

  // apb phases; zero wait states
  assign setup     = apbReq.psel && !apbReq.penable;
  assign acc       = apbReq.psel && apbReq.penable;
  assign wrRstCtrl = acc && apbReq.pwrite && apbReq.paddr == OFF_RST_CTRL;
  assign swFlagClr = wrRstCtrl && !apbReq.pwdata[RC_TO];
  assign pready    = 1'b1;
  assign pslverr   = acc && !addrHit(apbReq.paddr);

  // read data chosen at the setup edge so it is stable in the access phase
  always_comb begin
    rdMux = 32'h0000_0000;
    case (apbReq.paddr)
      OFF_RST_CTRL: begin
        rdMux[RC_SWEN]  = s.swEnable;
        rdMux[RC_TO]    = s.toFlag;
        rdMux[RC_SLEEP] = s.sleepSt;
        rdMux[RC_IDLE]  = s.idleSt;
      end
      OFF_ISTAT: rdMux[IRQ_N-1:0] = irqStatus;
      OFF_IMASK: rdMux[IRQ_N-1:0] = irqMask;
      OFF_CFG:   rdMux[9:0] = {on, ({1'b0, s.count} >= winStart), s.cfg};
      OFF_COUNT: rdMux[CNT_W-1:0] = s.count;
      default:   rdMux = 32'h0000_0000;
    endcase
  end

  // next state: bus writes first, hardware events after so a set wins
  always_comb begin
    next_s = s;
    next_s.resetReq = 1'b0;
    next_s.wakeReq = 1'b0;
    evt = '0;
    // configuration caught once after reset, then frozen
    if (!s.cfgLoaded) begin
      next_s.cfg = wdtConfigWord;
      next_s.cfgLoaded = 1'b1;
    end
    if (setup) begin
      next_s.prdata = rdMux;
    end
    // status bits are only cleared by software writing zero
    if (wrRstCtrl) begin
      next_s.swEnable = apbReq.pwdata[RC_SWEN];
      if (swFlagClr) begin
        next_s.toFlag = 1'b0;
      end
      if (!apbReq.pwdata[RC_SLEEP]) begin
        next_s.sleepSt = 1'b0;
      end
      if (!apbReq.pwdata[RC_IDLE]) begin
        next_s.idleSt = 1'b0;
      end
    end
    // a disabled watchdog restarts from zero when enabled again
    if (!on) begin
      next_s.count = '0;
    end else if (tick) begin
      next_s.count = CNT_W'(s.count + 1'b1);
    end
    case (s.mode)
      PM_RUN: begin
        if (watchdogClearOp) begin
          if (early) begin
            next_s.resetReq = 1'b1;
            next_s.toFlag = 1'b1;
            next_s.swEnable = 1'b0;
            evt[IRQ_EARLY] = 1'b1;
          end
          next_s.count = '0;
        end else if (timeout) begin
          next_s.resetReq = 1'b1;
          next_s.toFlag = 1'b1;
          // the requested reset is a device reset, so the enable drops
          next_s.swEnable = 1'b0;
          next_s.count = '0;
          evt[IRQ_TIMEOUT] = 1'b1;
        end
        if (powerSaveOp) begin
          next_s.mode = powerSaveIdle ? PM_IDLE : PM_SLEEP;
          next_s.idleSt = next_s.idleSt | powerSaveIdle;
          next_s.sleepSt = next_s.sleepSt | !powerSaveIdle;
          next_s.count = '0;
        end
      end
      PM_SLEEP, PM_IDLE: begin
        // a time-out in power-save wakes rather than resets
        if (timeout) begin
          next_s.wakeReq = 1'b1;
          next_s.toFlag = 1'b1;
          next_s.mode = PM_RUN;
          next_s.count = '0;
          evt[IRQ_TIMEOUT] = 1'b1;
          evt[IRQ_WAKE] = 1'b1;
        end else if (wakeEvent) begin
          next_s.mode = PM_RUN;
          next_s.count = '0;
        end
      end
      default: begin
        next_s.mode = PM_RUN;
      end
    endcase
    if (oscSwitchDone) begin
      next_s.count = '0;
    end
  end

  // asynchronous reset clears every counter and the sw enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{mode: PM_RUN, count: '0, cfg: wwd_cfg_t'(CFG_RST),
             cfgLoaded: 1'b0, swEnable: 1'b0, toFlag: 1'b0,
             sleepSt: 1'b0, idleSt: 1'b0, resetReq: 1'b0,
             wakeReq: 1'b0, prdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  // oscillator runs only while the watchdog is enabled
  wwd_osc_div #(
    .DIV(OSC_DIV)
  ) u_div (
    .ref_clk(ref_clk),
    .rst_n  (rst_n),
    .enable (on),
    .tick   (tick)
  );

  // only status bits shown by the setup read are cleared at the access edge
  wwd_irq #(
    .N(IRQ_N)
  ) u_irq (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .evt      (evt),
    .rdClr    (acc && !apbReq.pwrite && apbReq.paddr == OFF_ISTAT),
    .clrMask  (s.prdata[IRQ_N-1:0]),
    .maskWe   (acc && apbReq.pwrite && apbReq.paddr == OFF_IMASK),
    .maskWdata(apbReq.pwdata[IRQ_N-1:0]),
    .status   (irqStatus),
    .mask     (irqMask),
    .irq      (irq)
  );

  assign prdata          = s.prdata;
  assign wdtResetReq     = s.resetReq;
  assign wakeReq         = s.wakeReq;
  assign lowPowerRcOscOn = on;

  // checks on the counting and event logic
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_timeout_reset;
    timeout && s.mode == PM_RUN && !watchdogClearOp
      |=> wdtResetReq && s.toFlag && s.count == '0;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("running time-out did not request reset");

  property p_timeout_wake;
    timeout && s.mode != PM_RUN |=> wakeReq && s.mode == PM_RUN && !wdtResetReq;
  endproperty
  a_timeout_wake: assert property (p_timeout_wake)
    else $error("power-save time-out did not wake");

  property p_early_clear;
    s.mode == PM_RUN && watchdogClearOp && early |=> wdtResetReq ##1 !wdtResetReq;
  endproperty
  a_early_clear: assert property (p_early_clear)
    else $error("early clear did not give one reset pulse");

  property p_late_clear;
    s.mode == PM_RUN && watchdogClearOp && !early |=> !wdtResetReq && s.count == '0;
  endproperty
  a_late_clear: assert property (p_late_clear)
    else $error("accepted clear did not restart count");

  property p_off_quiet;
    s.cfgLoaded && s.cfg.hwEnableMode == HWEN_OFF
      |-> !lowPowerRcOscOn && !wdtResetReq && s.count == '0;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled watchdog active");

  property p_sleep_stop;
    s.cfg.hwEnableMode == HWEN_ACTIVE && s.mode == PM_SLEEP
      |-> !lowPowerRcOscOn ##1 !wakeReq;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("active-only mode ran in sleep");

  property p_flag_sticky;
    s.toFlag && !swFlagClr |=> s.toFlag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("time-out flag lost");

  property p_osc_on;
    s.count != '0 && $past(s.count) != s.count |-> $past(lowPowerRcOscOn);
  endproperty
  a_osc_on: assert property (p_osc_on)
    else $error("count advanced with oscillator off");

  property p_count_bound;
    s.cfgLoaded |-> s.count <= lastTick;
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("count beyond postscaled period");

  property p_cfg_hold;
    s.cfgLoaded |=> $stable(s.cfg) && s.cfgLoaded;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed after sampling");

  c_reset: cover property (timeout && s.mode == PM_RUN);
  c_wake: cover property (timeout && s.mode == PM_SLEEP);
  c_early: cover property (watchdogClearOp && early && s.mode == PM_RUN);
  c_window: cover property (watchdogClearOp && on && !s.cfg.windowDisable && !early);

endmodule // wwd_top

// *** sim/wwd_core_model.sv ***
// core model: clear, power-save, wake and clock-switch pulses
// assumes the bench calls op(); each pulse lasts one ref_clk cycle
module wwd_core_model
  import wwd_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic wakeReq,
  output logic      watchdogClearOp,
  output logic      powerSaveOp,
  output logic      powerSaveIdle,
  output logic      wakeEvent,
  output logic      oscSwitchDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic asleep;

  initial begin
    {watchdogClearOp, powerSaveOp, powerSaveIdle, wakeEvent, oscSwitchDone} = 5'h00;
  end

  // a sleeping core runs no code, so it resumes only on a wake
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n || wakeReq || wakeEvent) begin
      asleep <= 1'b0;
    end else if (powerSaveOp) begin
      asleep <= 1'b1;
    end
  end

  // kind: 0 clear, 1 power save, 2 wake, 3 clock switch done
  task op(input int kind, input logic idle);
    @(posedge ref_clk);
    if (kind == 0 && !asleep) begin
      watchdogClearOp <= 1'b1;
    end
    if (kind == 1 && !asleep) begin
      powerSaveOp <= 1'b1;
      powerSaveIdle <= idle;
    end
    wakeEvent <= (kind == 2);
    oscSwitchDone <= (kind == 3);
    @(posedge ref_clk);
    {watchdogClearOp, powerSaveOp, wakeEvent, oscSwitchDone} <= 4'h0;
  endtask
endmodule // wwd_core_model

// *** sim/wwd_top_tb.sv ***
// self-checking bench of the windowed watchdog with an apb master
// assumes OSC_DIV shortened to 2 so every period the tests wait out fits in a short run
module wwd_top_tb
  import wwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 2;
  logic         ref_clk;
  logic         rst_n;
  wwd_apb_req_t apbReq;
  wwd_cfg_t     cfg;
  logic [31:0]  prdata;
  logic [31:0]  rdata;
  logic         pready, pslverr, rerr, wdtResetReq, wakeReq, oscOn, irq;
  logic         clrOp, psOp, psIdle, wakeEvt, oscDone;
  int           numErrors, samplesChecked, n;

  wwd_top #(.OSC_DIV(DIV)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdtConfigWord(cfg),
    .watchdogClearOp(clrOp), .powerSaveOp(psOp), .powerSaveIdle(psIdle),
    .wakeEvent(wakeEvt), .oscSwitchDone(oscDone), .wdtResetReq(wdtResetReq),
    .wakeReq(wakeReq), .lowPowerRcOscOn(oscOn), .irq(irq));
  wwd_core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .wakeReq(wakeReq),
    .watchdogClearOp(clrOp), .powerSaveOp(psOp), .powerSaveIdle(psIdle),
    .wakeEvent(wakeEvt), .oscSwitchDone(oscDone));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    // no local limit: only the bench watchdog ends a hung transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task do_reset(input logic wd, input logic [1:0] md, input logic ps, input logic [3:0] po);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    cfg <= '{wd, md, ps, po};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  // n counts edges until the pulse is seen, or reaches maxc
  task wait_sig(input bit wake, input int maxc);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((wake ? wakeReq : wdtResetReq) !== 1'b1 && n < maxc);
  endtask

  task t_regs;
    do_reset(1'b1, HWEN_SW, 1'b0, 4'h3);
    apb(1'b0, OFF_RST_CTRL, 32'h0);
    check("reset ctrl at reset", 32'h0, rdata);
    check("osc sw off", 32'h0, oscOn);
    cfg <= '{1'b0, HWEN_ON, 1'b1, 4'hF};
    apb(1'b1, OFF_RST_CTRL, 32'h20);
    #1;
    check("osc sw on", 32'h1, oscOn);
    apb(1'b0, OFF_CFG, 32'h0);
    check("sampled cfg", 32'h1C3, {rdata[9], rdata[7:0]});
    repeat (30) @(posedge ref_clk);
    u_core.op(3, 1'b0);
    apb(1'b0, OFF_COUNT, 32'h0);
    check("count after switch", 32'h1, rdata < 4);
    repeat (30) @(posedge ref_clk);
    u_core.op(0, 1'b0);
    apb(1'b0, OFF_COUNT, 32'h0);
    check("count after clear", 32'h1, rdata < 4);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", 32'h1, rerr);
    check("unmapped data", 32'h0, rdata);
    $display("test regs done");
  endtask

  task t_period;
    int e;
    for (int k = 0; k < 3; k++) begin
      do_reset(1'b1, HWEN_ON, k == 1, (k == 2) ? 4'h2 : 4'h0);
      e = ((k == 1) ? PRESC_LARGE : PRESC_SMALL) * ((k == 2) ? 4 : 1) * DIV;
      wait_sig(1'b0, 1000);
      check("period", 32'h1, n >= e - DIV - 4 && n <= e + DIV + 4);
      if (k == 0) begin
        apb(1'b0, OFF_RST_CTRL, 32'h0);
        check("flag set", 32'h1, rdata[RC_TO]);
        check("irq masked", 32'h0, irq);
        apb(1'b1, OFF_IMASK, 32'h7);
        #1;
        check("irq raised", 32'h1, irq);
        apb(1'b0, OFF_ISTAT, 32'h0);
        check("status", 32'h1, rdata[2:0]);
        #1;
        check("irq cleared", 32'h0, irq);
        apb(1'b0, OFF_RST_CTRL, 32'h0);
        check("flag sticky", 32'h1, rdata[RC_TO]);
        apb(1'b1, OFF_RST_CTRL, 32'h0);
        apb(1'b0, OFF_RST_CTRL, 32'h0);
        check("flag cleared", 32'h0, rdata[RC_TO]);
      end
    end
    $display("test period done");
  endtask

  task t_window;
    do_reset(1'b0, HWEN_ON, 1'b0, 4'h2);
    repeat (20) @(posedge ref_clk);
    u_core.op(0, 1'b0);
    wait_sig(1'b0, 3);
    check("early clear reset", 32'h1, n);
    apb(1'b0, OFF_ISTAT, 32'h0);
    check("early status", 32'h1, rdata[IRQ_EARLY]);
    repeat (200) @(posedge ref_clk);
    u_core.op(0, 1'b0);
    wait_sig(1'b0, 40);
    check("late clear ok", 32'd40, n);
    do_reset(1'b0, HWEN_OFF, 1'b0, 4'h2);
    repeat (20) @(posedge ref_clk);
    u_core.op(0, 1'b0);
    wait_sig(1'b0, 40);
    check("off early clear", 32'd40, n);
    check("off osc", 32'h0, oscOn);
    $display("test window done");
  endtask

  task t_sleep;
    do_reset(1'b1, HWEN_ON, 1'b0, 4'h0);
    for (int k = 0; k < 2; k++) begin
      repeat (10) @(posedge ref_clk);
      u_core.op(1, k == 1);
      wait_sig(1'b1, 100);
      check("sleep wake", 32'h1, n > 56 && n < 72);
      apb(1'b0, OFF_ISTAT, 32'h0);
      check("wake irq status", 32'h5, rdata[2:0]);
      apb(1'b0, OFF_RST_CTRL, 32'h0);
      check("wake status", (k == 1) ? 32'h5 : 32'h6, rdata[4:2]);
      apb(1'b1, OFF_RST_CTRL, 32'h0);
      apb(1'b0, OFF_RST_CTRL, 32'h0);
      check("status cleared", 32'h0, rdata[4:2]);
    end
    do_reset(1'b1, HWEN_ACTIVE, 1'b0, 4'h0);
    u_core.op(1, 1'b0);
    #1;
    check("active sleep osc", 32'h0, oscOn);
    wait_sig(1'b1, 200);
    check("no sleep wake", 32'd200, n);
    u_core.op(2, 1'b0);
    #1;
    check("active run osc", 32'h1, oscOn);
    u_core.op(1, 1'b1);
    wait_sig(1'b1, 100);
    check("idle wake", 32'h1, n < 100);
    $display("test sleep done");
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, well beyond the roughly 1500 cycles the tests need
  initial begin
    #3_000_000;
    numErrors++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    cfg = '0;
    numErrors = 0;
    samplesChecked = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_period();
    t_window();
    t_sleep();
    end_of_test();
  end
endmodule // wwd_top_tb
